// ==== hdl/rpo_pin_select.sv ====
module rpo_pin_select (
   input  wire logic                           ref_clk,
   input  wire logic                           sys_rst,
   input  wire rpo_pkg::rpo_req_t              req,
   output logic      [rpo_pkg::DATA_W-1:0]     rdata_q,
   input  wire logic [rpo_pkg::NPER-1:0]       periph_out,
   output logic      [rpo_pkg::NPIN-1:0]       remappable_pin,
   output logic                                mapping_lock_q
);
   // pin index: 0=pin2 1=pin3 2=pin16 3=pin17 4=pin18 5=pin19
   logic [rpo_pkg::SEL_W-1:0] sel [rpo_pkg::NPIN];
   logic [rpo_pkg::NPIN-1:0]  wr_en;
   logic                      map_wr_ok;
   logic [rpo_pkg::DATA_W-1:0] rd_d;

   assign map_wr_ok = req.wr && !mapping_lock_q;

   always_comb begin
      wr_en = '0;
      if (map_wr_ok) begin
         case (req.addr)
            rpo_pkg::OFF_MAP_2_3:   wr_en = 6'h03;
            rpo_pkg::OFF_MAP_16_17: wr_en = 6'h0C;
            rpo_pkg::OFF_MAP_18_19: wr_en = 6'h30;
            default:                wr_en = '0;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < rpo_pkg::NPIN; g++) begin : g_pin
         rpo_sel_field u_field (
            .ref_clk    (ref_clk),
            .sys_rst    (sys_rst),
            .wr_en      (wr_en[g]),
            // odd index takes the high field, even the low; bits 15..14, 7..6 dropped
            .wr_val     ((g % 2 == 1) ?
                         req.wdata[rpo_pkg::HI_LSB +: rpo_pkg::SEL_W] :
                         req.wdata[rpo_pkg::LO_LSB +: rpo_pkg::SEL_W]),
            .periph_out (periph_out),
            .sel_q      (sel[g]),
            .pin_q      (remappable_pin[g])
         );
      end
   endgenerate

   // lock register is always writable so software can also release it
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mapping_lock_q <= 1'b0;
      end else if (req.wr && req.addr == rpo_pkg::OFF_LOCK) begin
         mapping_lock_q <= req.wdata[rpo_pkg::LOCK_BIT];
      end
   end

   always_comb begin
      rd_d = '0;
      case (req.addr)
         rpo_pkg::OFF_MAP_2_3:   rd_d = {2'h0, sel[1], 2'h0, sel[0]};
         rpo_pkg::OFF_MAP_16_17: rd_d = {2'h0, sel[3], 2'h0, sel[2]};
         rpo_pkg::OFF_MAP_18_19: rd_d = {2'h0, sel[5], 2'h0, sel[4]};
         rpo_pkg::OFF_LOCK:      rd_d = {15'h0000, mapping_lock_q};
         default:                rd_d = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_q <= '0;
      end else if (req.rd) begin
         rdata_q <= rd_d;
      end else begin
         rdata_q <= '0;
      end
   end

   a_lock_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mapping_lock_q && req.wr && req.addr == rpo_pkg::OFF_MAP_2_3) |=>
      ({sel[1], sel[0]} == $past({sel[1], sel[0]})))
      else $error("mapping changed while locked");
   a_write_lands: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!mapping_lock_q && req.wr && req.addr == rpo_pkg::OFF_MAP_2_3) |=>
      (sel[1] == $past(req.wdata[13:8]) && sel[0] == $past(req.wdata[5:0])))
      else $error("pin 2/3 write not stored");
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(req.rd) |-> (rdata_q & ~rpo_pkg::IMPL_MASK) == '0)
      else $error("reserved bits read nonzero");
   a_null_pin: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (sel[3] == rpo_pkg::SEL_NULL) ##1 (sel[3] == rpo_pkg::SEL_NULL) |-> !remappable_pin[3])
      else $error("null select drives pin 17");
   a_route_pin19: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (sel[5] != rpo_pkg::SEL_NULL && $stable(sel[5])) |=>
      remappable_pin[5] == $past(periph_out[sel[5]]))
      else $error("pin 19 route wrong");
   a_read_back: assert property (@(posedge ref_clk) disable iff (sys_rst)
      req.rd && req.addr == rpo_pkg::OFF_MAP_18_19 |=>
      rdata_q == {2'h0, $past(sel[5]), 2'h0, $past(sel[4])})
      else $error("pin 18/19 readback wrong");
   a_rdata_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !req.rd |=> rdata_q == '0)
      else $error("read data outside read slot");
   a_lock_hold_upper: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mapping_lock_q && req.wr && req.addr == rpo_pkg::OFF_MAP_18_19) |=>
      ({sel[5], sel[4]} == $past({sel[5], sel[4]})))
      else $error("pin 18/19 mapping changed while locked");
   a_write_mid: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!mapping_lock_q && req.wr && req.addr == rpo_pkg::OFF_MAP_16_17) |=>
      (sel[3] == $past(req.wdata[13:8]) && sel[2] == $past(req.wdata[5:0])))
      else $error("pin 16/17 write not stored");
   a_route_pin2: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (sel[0] != rpo_pkg::SEL_NULL && $stable(sel[0])) |=>
      remappable_pin[0] == $past(periph_out[sel[0]]))
      else $error("pin 2 route wrong");
   a_lock_reset: assert property (@(posedge ref_clk)
      sys_rst |=> !mapping_lock_q)
      else $error("lock not clear after reset");

   c_map_write: cover property (@(posedge ref_clk) map_wr_ok && req.addr == rpo_pkg::OFF_MAP_16_17);
   c_lock_set:  cover property (@(posedge ref_clk) $rose(mapping_lock_q));
   c_blocked:   cover property (@(posedge ref_clk) mapping_lock_q && req.wr && req.addr == rpo_pkg::OFF_MAP_2_3);
endmodule

// ==== hdl/rpo_pkg.sv ====
// Operation
// - pin 3 driven by select field bits 13..8
// - pin 2 driven by select field bits 5..0
// - bits 15..14 read zero, writes ignored
// - bits 7..6 read zero, writes ignored
// - mapping bits read/write, reset to zero
// - third register holds pin 16 and 17 fields
// - pin 17 driven by its selected output
// - pin 18 from fourth register bits 5..0
// - pin 19 from fourth register bits 13..8
// - select zero leaves pin disconnected
// - lock resets clear, blocks mapping writes
package rpo_pkg;
   localparam int SEL_W   = 6;
   localparam int NPER    = 64;
   localparam int NPIN    = 6;
   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 16;
   localparam logic [ADDR_W-1:0] OFF_MAP_2_3   = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_MAP_16_17 = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_MAP_18_19 = 4'h9;
   localparam logic [ADDR_W-1:0] OFF_LOCK      = 4'hF;
   localparam int LO_LSB  = 0;
   localparam int HI_LSB  = 8;
   localparam int LOCK_BIT = 0;
   localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
   localparam logic [SEL_W-1:0] SEL_NULL  = 6'h00;
   localparam logic [DATA_W-1:0] IMPL_MASK = 16'h3F3F;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rpo_req_t;
endpackage

// ==== hdl/rpo_sel_field.sv ====
module rpo_sel_field (
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   input  wire logic                         wr_en,
   input  wire logic [rpo_pkg::SEL_W-1:0]    wr_val,
   input  wire logic [rpo_pkg::NPER-1:0]     periph_out,
   output logic      [rpo_pkg::SEL_W-1:0]    sel_q,
   output logic                              pin_q
);
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sel_q <= rpo_pkg::SEL_RESET;
      end else if (wr_en) begin
         sel_q <= wr_val;
      end
   end

   // registered so the pin is glitch free; data only, no direction or enable
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_q <= 1'b0;
      end else if (sel_q == rpo_pkg::SEL_NULL) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= periph_out[sel_q];
      end
   end
endmodule

// ==== verif/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                       ref_clk;
   logic                       sys_rst;
   rpo_pkg::rpo_req_t          req;
   logic [15:0]                rdata_q;
   logic [63:0]                periph_out;
   logic [5:0]                 remappable_pin;
   logic                       mapping_lock_q;
   int                         mismatches, check_count;
   logic [15:0]                exp_q[$];
   logic [5:0]                 sel_m[6];
   logic                       lk, rd_d;
   logic [31:0]                seed = 32'h38;
   logic [3:0]                 addrs[3] = '{4'h1, 4'h8, 4'h9};

   rpo_pin_select dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rdata_q(rdata_q),
      .periph_out(periph_out), .remappable_pin(remappable_pin),
      .mapping_lock_q(mapping_lock_q));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // the model follows the lock, so a refused write leaves the old selects expected
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      for (int k = 0; k < 3; k++) if (a == addrs[k] && !lk) begin
         sel_m[2*k] = d[5:0];
         sel_m[2*k+1] = d[13:8];
      end
      if (a == rpo_pkg::OFF_LOCK) lk = d[0];
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [3:0] a);
      logic [15:0] e;
      e = (a == rpo_pkg::OFF_LOCK) ? {15'h0, lk} : 16'h0;
      for (int k = 0; k < 3; k++) if (a == addrs[k]) e = {2'b0, sel_m[2*k+1], 2'b0, sel_m[2*k]};
      req <= '{a, 16'h0, 1'b0, 1'b1};
      exp_q.push_back(e);
      @(posedge ref_clk);
   endtask

   // output 0 is held high so a null select that leaks it shows up
   task automatic chk_pins();
      logic [63:0] v;
      logic [5:0]  e;
      v = {rnd(), rnd() | 32'h1};
      req <= '0;
      periph_out <= v;
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < 6; i++) e[i] = (sel_m[i] == 6'h00) ? 1'b0 : v[sel_m[i]];
      cmp({10'h0, remappable_pin}, {10'h0, e});
      cmp({15'h0, mapping_lock_q}, {15'h0, lk});
   endtask

   task automatic do_reset();
      sys_rst <= 1'b1;
      lk = 1'b0;
      for (int i = 0; i < 6; i++) sel_m[i] = 6'h00;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so it is sampled exactly there
   always @(posedge ref_clk) begin
      rd_d <= req.rd & ~sys_rst;
      if (rd_d) cmp(rdata_q, exp_q.pop_front());
   end

   initial begin
      repeat (2000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end

   initial begin
      logic [15:0] d;
      req = '0;
      periph_out = '0;
      do_reset();
      for (int k = 0; k < 3; k++) rd(addrs[k]);
      chk_pins();
      repeat (6) begin
         for (int k = 0; k < 3; k++) begin
            d = 16'(rnd());
            wr(addrs[k], d);
         end
         for (int k = 0; k < 3; k++) rd(addrs[k]);
         chk_pins();
      end
      wr(4'h3, 16'hFFFF);
      rd(4'h3);
      wr(rpo_pkg::OFF_LOCK, 16'h0001);
      wr(addrs[0], 16'hFFFF);
      rd(addrs[0]);
      rd(rpo_pkg::OFF_LOCK);
      chk_pins();
      wr(rpo_pkg::OFF_LOCK, 16'h0000);
      wr(addrs[0], 16'hC2C1);
      rd(addrs[0]);
      chk_pins();
      do_reset();
      for (int k = 0; k < 3; k++) rd(addrs[k]);
      chk_pins();
      finish_test();
   end
endmodule
